// File: verilog/clock_security_output_gating.sv
// Clock controller registers: peripheral gate bank two, security
// monitor with auxiliary fallback, clock output selector, RC trim
// and debug clock divider. Clock sources arrive as same-clock
// levels from the clock generator; the failure input is async.
`default_nettype none

module clock_security_output_gating
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic [6:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Oscillator status and clock sources
  input  wire logic        xtalFailAsync,
  input  wire logic        fastRcReady,
  input  wire logic        slowRcReady,
  input  wire logic        xtalReady,
  input  wire logic        srcHsiDiv,
  input  wire logic        srcSlow,
  input  wire logic        srcXtal,
  input  wire logic        srcFast,
  input  wire logic        srcCpu,
  input  wire logic        srcMaster,
  input  wire logic        trimThreeBit,
  // Clock gates and control outputs
  output logic             canClkEn,
  output logic             adcClkEn,
  output logic             awuClkEn,
  output logic      [7:0]  masterSelect,
  output logic             fastRcEnable,
  output logic             auxActive,
  output logic      [3:0]  rcTrimValue,
  output logic             debugClkEn,
  output logic             clockOutputPin,
  // Interrupts
  output logic             failureIrq,
  output logic             irq
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstSync1_q;
  logic rst_n;

  // Deassert in step with the clock, assert at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rst_n      <= rstSync1_q;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic        waitReq_q;
  logic [4:0]  regIdx;
  logic        wrAcc;
  logic [7:0]  wdat;

  assign regIdx = address[6:2];
  assign wdat   = writedata[7:0];
  // Write takes effect on the edge where waitrequest is seen low
  assign wrAcc  = write && !waitReq_q;

  function automatic logic wrHit(input logic [4:0] idx);
    wrHit = wrAcc && (regIdx == idx);
  endfunction : wrHit

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] gate2_q;
  logic [7:0] gate1_q;
  logic [7:0] div_q;
  logic [7:0] msel_q;
  logic       fastEn_q;
  logic       flag_q;
  logic       failIe_q;
  logic       aux_q;
  logic       monEn_q;
  logic       monWritten_q;
  logic       coBusy_q;
  logic       coReady_q;
  logic [3:0] coSel_q;
  logic       coEn_q;
  logic [3:0] trim_q;
  logic       dbgUndiv_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqEn_q;

  // ----------------------------------------
  // Failure input synchroniser
  // ----------------------------------------
  logic failS1_q;
  logic failS2_q;
  logic failS3_q;
  logic failLvl_q;
  logic failEvent;

  // Three stages; the level moves only when stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      failS1_q  <= 1'b0;
      failS2_q  <= 1'b0;
      failS3_q  <= 1'b0;
      failLvl_q <= 1'b0;
    end else begin
      failS1_q <= xtalFailAsync;
      failS2_q <= failS1_q;
      failS3_q <= failS2_q;
      if (failS2_q == failS3_q) begin
        failLvl_q <= failS3_q;
      end
    end
  end

  assign failEvent = failLvl_q && monEn_q && !aux_q;

  // ----------------------------------------
  // Peripheral gate banks
  // ----------------------------------------
  // All gates open out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate2_q <= RST_GATE;
      gate1_q <= RST_GATE;
    end else begin
      if (wrHit(IDX_GATE2)) begin
        gate2_q <= wdat;
      end
      if (wrHit(IDX_GATE1)) begin
        gate1_q <= wdat;
      end
    end
  end

  // Route named bits to their peripherals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      canClkEn <= 1'b1;
      adcClkEn <= 1'b1;
      awuClkEn <= 1'b1;
    end else begin
      canClkEn <= gate2_q[GATE_CAN];
      adcClkEn <= gate2_q[GATE_ADC];
      awuClkEn <= gate2_q[GATE_AWU];
    end
  end

  // ----------------------------------------
  // Master select, divider, fast RC enable
  // ----------------------------------------
  // Switching itself lives elsewhere; only storage and forcing here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msel_q   <= RST_MSEL;
      div_q    <= RST_DIV;
      fastEn_q <= 1'b1;
    end else begin
      if (wrHit(IDX_DIV)) begin
        div_q <= wdat;
      end
      if (aux_q || failEvent) begin
        msel_q <= RST_MSEL;
      end else if (wrHit(IDX_MSEL)) begin
        msel_q <= wdat;
      end
      // Fast RC held on under fallback
      if (aux_q || failEvent) begin
        fastEn_q <= 1'b1;
      end else if (wrHit(IDX_INT_CTRL)) begin
        fastEn_q <= wdat[0];
      end
    end
  end

  // ----------------------------------------
  // Security monitor
  // ----------------------------------------
  // Everything off after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q       <= 1'b0;
      failIe_q     <= 1'b0;
      aux_q        <= 1'b0;
      monEn_q      <= 1'b0;
      monWritten_q <= 1'b0;
    end else begin
      // Set beats a write-0 clear in the same cycle
      if (failEvent) begin
        flag_q <= 1'b1;
      end else if (wrHit(IDX_SECURITY) && !wdat[SEC_FLAG]) begin
        flag_q <= 1'b0;
      end
      if (wrHit(IDX_SECURITY)) begin
        failIe_q <= wdat[SEC_IE];
      end
      // Only the first write reaches the enable
      if (wrHit(IDX_SECURITY) && !monWritten_q) begin
        monEn_q      <= wdat[SEC_EN];
        monWritten_q <= 1'b1;
      end
      // Aux stays until reset; no return path defined
      if (failEvent) begin
        aux_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Clock output handshake
  // ----------------------------------------
  logic srcReady;
  logic selWrite;

  // Oscillator-based sources wait for their ready; derived ones are live
  always_comb begin
    unique case (coSel_q)
      SRC_HSIDIV: srcReady = fastRcReady;
      SRC_FAST:   srcReady = fastRcReady;
      SRC_SLOW:   srcReady = slowRcReady;
      SRC_XTAL:   srcReady = xtalReady;
      default:    srcReady = 1'b1;
    endcase
  end

  // Select field locked while busy
  // Spelled out so the assign is sensitive to every term it reads
  assign selWrite = wrAcc && (regIdx == IDX_CLKOUT) && !coBusy_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coSel_q   <= 4'h0;
      coEn_q    <= 1'b0;
      coBusy_q  <= 1'b0;
      coReady_q <= 1'b0;
    end else begin
      if (wrHit(IDX_CLKOUT)) begin
        coEn_q <= wdat[CO_EN];
      end
      if (selWrite) begin
        coSel_q <= wdat[CO_SEL_LO +: 4];
      end
      // Ready only while the pin is driven
      if (wrHit(IDX_CLKOUT) && !wdat[CO_EN]) begin
        coBusy_q  <= 1'b0;
        coReady_q <= 1'b0;
      end else if (selWrite && wdat[CO_EN]) begin
        // New request or new source: restart stabilisation
        coBusy_q  <= 1'b1;
        coReady_q <= 1'b0;
      end else if (coBusy_q && srcReady) begin
        // Busy ends as the output comes on
        coBusy_q  <= 1'b0;
        coReady_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Output clock selection
  // ----------------------------------------
  logic       cpuPrev_q;
  logic [5:0] cpuCnt_q;
  logic       outSel;

  // Count CPU clock rising edges; bit k gives CPU/2^(k+1)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuPrev_q <= 1'b0;
      cpuCnt_q  <= 6'h00;
    end else begin
      cpuPrev_q <= srcCpu;
      if (srcCpu && !cpuPrev_q) begin
        cpuCnt_q <= cpuCnt_q + 6'h01;
      end
    end
  end

  // Source decode, reserved code 3 drives low
  always_comb begin
    unique case (coSel_q)
      SRC_HSIDIV: outSel = srcHsiDiv;
      SRC_SLOW:   outSel = srcSlow;
      SRC_XTAL:   outSel = srcXtal;
      4'h3:       outSel = 1'b0;
      SRC_CPU1:   outSel = srcCpu;
      4'h5:       outSel = cpuCnt_q[0];
      4'h6:       outSel = cpuCnt_q[1];
      4'h7:       outSel = cpuCnt_q[2];
      4'h8:       outSel = cpuCnt_q[3];
      4'h9:       outSel = cpuCnt_q[4];
      SRC_CPU64:  outSel = cpuCnt_q[5];
      SRC_FAST:   outSel = srcFast;
      SRC_MASTER: outSel = srcMaster;
      default:    outSel = srcCpu;
    endcase
  end

  // Pin quiet unless enabled and ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clockOutputPin <= 1'b0;
    end else begin
      clockOutputPin <= coReady_q && coEn_q && outSel;
    end
  end

  // ----------------------------------------
  // Trim and debug clock
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q     <= 4'h0;
      dbgUndiv_q <= 1'b0;
    end else begin
      // Top trim bit dropped in three-bit mode
      if (wrHit(IDX_TRIM)) begin
        trim_q <= {wdat[3] && !trimThreeBit, wdat[2:0]};
      end
      if (wrHit(IDX_DEBUG)) begin
        dbgUndiv_q <= wdat[0];
      end
    end
  end

  // Enable every cycle, or every other one when halved
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debugClkEn <= 1'b0;
    end else begin
      debugClkEn <= dbgUndiv_q || !debugClkEn;
    end
  end

  // ----------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------
  logic coReadyRise;

  assign coReadyRise = coBusy_q && srcReady && coEn_q;

  // Sticky events; a new event wins over a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_q <= 2'b00;
      irqEn_q   <= 2'b00;
    end else begin
      if (wrHit(IDX_IRQ_EN)) begin
        irqEn_q <= wdat[1:0];
      end
      irqStat_q <= (irqStat_q & ~(wrHit(IDX_IRQ_CLR) ? wdat[1:0] : 2'b00))
                 | {coReadyRise, failEvent};
    end
  end

  // Level interrupts registered out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      failureIrq <= 1'b0;
      irq        <= 1'b0;
    end else begin
      failureIrq <= flag_q && failIe_q;
      irq        <= |(irqStat_q & irqEn_q);
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      masterSelect <= RST_MSEL;
      fastRcEnable <= 1'b1;
      auxActive    <= 1'b0;
      rcTrimValue  <= 4'h0;
    end else begin
      masterSelect <= msel_q;
      fastRcEnable <= fastEn_q;
      // Aux visible on a port too
      auxActive    <= aux_q;
      rcTrimValue  <= trim_q;
    end
  end

  // ----------------------------------------
  // Read mux and handshake
  // ----------------------------------------
  logic [7:0] rdMux;

  // Reserved bits and unmapped indices read as zero
  always_comb begin
    unique case (regIdx)
      IDX_INT_CTRL: rdMux = {7'h00, fastEn_q};
      IDX_EXT_CTRL: rdMux = {6'h00, xtalReady, 1'b0};
      IDX_MSTAT:    rdMux = msel_q;
      IDX_MSEL:     rdMux = msel_q;
      IDX_DIV:      rdMux = div_q;
      IDX_GATE1:    rdMux = gate1_q;
      IDX_SECURITY: rdMux = {4'h0, flag_q, failIe_q, aux_q, monEn_q};
      IDX_CLKOUT:   rdMux = {1'b0, coBusy_q, coReady_q, coSel_q, coEn_q};
      IDX_GATE2:    rdMux = gate2_q;
      IDX_TRIM:     rdMux = {4'h0, trim_q};
      IDX_DEBUG:    rdMux = {7'h00, dbgUndiv_q};
      IDX_IRQ_STAT: rdMux = {6'h00, irqStat_q};
      IDX_IRQ_EN:   rdMux = {6'h00, irqEn_q};
      default:      rdMux = 8'h00;
    endcase
  end

  // One wait state per access; waitrequest idles high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReq_q <= 1'b1;
      readdata  <= 32'h0000_0000;
    end else begin
      if ((read || write) && waitReq_q) begin
        waitReq_q <= 1'b0;
        readdata  <= {24'h00_0000, rdMux};
      end else begin
        waitReq_q <= 1'b1;
      end
    end
  end

  assign waitrequest = waitReq_q;

endmodule : clock_security_output_gating

`default_nettype wire

// File: verilog/clk_ctrl_pkg.sv
// Constants for the clock security and output gating block.
// Assumes word-aligned Avalon-MM byte addresses (index * 4).
`default_nettype none

package clk_ctrl_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4*index)
  // ----------------------------------------
  localparam logic [4:0] IDX_INT_CTRL  = 5'h00;
  localparam logic [4:0] IDX_EXT_CTRL  = 5'h01;
  localparam logic [4:0] IDX_MSTAT     = 5'h03;
  localparam logic [4:0] IDX_MSEL      = 5'h04;
  localparam logic [4:0] IDX_SWCTL     = 5'h05;
  localparam logic [4:0] IDX_DIV       = 5'h06;
  localparam logic [4:0] IDX_GATE1     = 5'h07;
  localparam logic [4:0] IDX_SECURITY  = 5'h08;
  localparam logic [4:0] IDX_CLKOUT    = 5'h09;
  localparam logic [4:0] IDX_GATE2     = 5'h0A;
  localparam logic [4:0] IDX_TRIM      = 5'h0C;
  localparam logic [4:0] IDX_DEBUG     = 5'h0D;
  localparam logic [4:0] IDX_IRQ_STAT  = 5'h10;
  localparam logic [4:0] IDX_IRQ_CLR   = 5'h11;
  localparam logic [4:0] IDX_IRQ_EN    = 5'h12;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_GATE      = 8'hFF;
  localparam logic [7:0] RST_MSEL      = 8'hE1;
  localparam logic [7:0] RST_DIV       = 8'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int GATE_CAN  = 7;
  localparam int GATE_ADC  = 3;
  localparam int GATE_AWU  = 2;
  localparam int SEC_FLAG  = 3;
  localparam int SEC_IE    = 2;
  localparam int SEC_AUX   = 1;
  localparam int SEC_EN    = 0;
  localparam int CO_BUSY   = 6;
  localparam int CO_READY  = 5;
  localparam int CO_SEL_LO = 1;
  localparam int CO_EN     = 0;
  localparam int EV_FAIL   = 0;
  localparam int EV_CORDY  = 1;

  // ----------------------------------------
  // Output source codes
  // ----------------------------------------
  localparam logic [3:0] SRC_HSIDIV = 4'h0;
  localparam logic [3:0] SRC_SLOW   = 4'h1;
  localparam logic [3:0] SRC_XTAL   = 4'h2;
  localparam logic [3:0] SRC_CPU1   = 4'h4;
  localparam logic [3:0] SRC_CPU64  = 4'hA;
  localparam logic [3:0] SRC_FAST   = 4'hB;
  localparam logic [3:0] SRC_MASTER = 4'hC;
endpackage : clk_ctrl_pkg

`default_nettype wire

// File: sim/clock_security_output_gating_assertions.sv
// Port checker for the clock security and output gating block.
// Assumes binding to the top module; bus answers after one wait state.
`default_nettype none

module cs_gating_checker
  import clk_ctrl_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [6:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  // Watched status and outputs
  input wire logic        xtalFailAsync,
  input wire logic        canClkEn,
  input wire logic        adcClkEn,
  input wire logic [7:0]  masterSelect,
  input wire logic        fastRcEnable,
  input wire logic        auxActive,
  input wire logic        debugClkEn,
  input wire logic        failureIrq
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] upCnt_q;
  logic       live;
  logic       wrGate2;

  // Internal reset lags two flops, so hold off until it has settled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) upCnt_q <= 3'h0;
    else if (upCnt_q != 3'h6) upCnt_q <= upCnt_q + 3'h1;
  end
  assign live    = (upCnt_q == 3'h6);
  assign wrGate2 = write && !waitrequest && (address[6:2] == IDX_GATE2);

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_oneWait;
    (read || write) && !waitrequest |=> waitrequest;
  endproperty
  a_oneWait: assert property (p_oneWait) else $error("wait state not restored");
  property p_answer;
    live && $rose(read || write) |-> waitrequest ##1 !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not after one wait");
  property p_canGate;
    live && $changed(canClkEn) |-> $past(wrGate2, 2) && canClkEn == $past(writedata[GATE_CAN], 2);
  endproperty
  a_canGate: assert property (p_canGate) else $error("bus gate bit seven mismatch");
  property p_adcGate;
    live && $changed(adcClkEn) |-> $past(wrGate2, 2) && adcClkEn == $past(writedata[GATE_ADC], 2);
  endproperty
  a_adcGate: assert property (p_adcGate) else $error("converter gate mismatch");
  property p_auxHold;
    auxActive |=> auxActive;
  endproperty
  a_auxHold: assert property (p_auxHold) else $error("aux dropped without reset");
  property p_auxCause;
    live && $rose(auxActive) |-> $past(xtalFailAsync, 2);
  endproperty
  a_auxCause: assert property (p_auxCause) else $error("aux set with no failure");
  property p_selForce;
    live && $rose(auxActive) |-> ##[0:1] masterSelect == RST_MSEL;
  endproperty
  a_selForce: assert property (p_selForce) else $error("master select not forced");
  property p_rcForce;
    auxActive |=> fastRcEnable;
  endproperty
  a_rcForce: assert property (p_rcForce) else $error("fast RC off during aux");
  property p_irqCause;
    failureIrq |-> auxActive;
  endproperty
  a_irqCause: assert property (p_irqCause) else $error("failure irq with no failure");
  property p_dbgPulse;
    live && !debugClkEn |=> debugClkEn;
  endproperty
  a_dbgPulse: assert property (p_dbgPulse) else $error("debug enable low twice");
endmodule : cs_gating_checker

bind clock_security_output_gating cs_gating_checker chk (
  .clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .waitrequest(waitrequest), .xtalFailAsync(xtalFailAsync),
  .canClkEn(canClkEn), .adcClkEn(adcClkEn), .masterSelect(masterSelect),
  .fastRcEnable(fastRcEnable), .auxActive(auxActive), .debugClkEn(debugClkEn),
  .failureIrq(failureIrq)
);

`default_nettype wire

// File: sim/clock_source_model.sv
// Far-side model: oscillator status and clock source waveforms.
// Assumes the block's clock; the bench commands crystal on and failure.
`default_nettype none

module clock_source_model (
  // Clock, reset and bench commands
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic failCmd,
  input  wire logic xtalOn,
  // Oscillator status
  output logic      xtalFailAsync,
  output logic      fastRcReady,
  output logic      slowRcReady,
  output logic      xtalReady,
  // Source waveforms as same-clock levels
  output logic      srcHsiDiv,
  output logic      srcSlow,
  output logic      srcXtal,
  output logic      srcFast,
  output logic      srcCpu,
  output logic      srcMaster
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] phase_q;

  // Free-running phase gives each source its own pattern
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) phase_q <= 4'h0;
    else phase_q <= phase_q + 4'h1;
  end

  // Crystal stands still while off, so a dead source shows low
  assign srcXtal       = phase_q[1] & xtalOn;
  assign srcFast       = phase_q[0];
  assign srcSlow       = phase_q[2];
  assign srcHsiDiv     = phase_q[3];
  assign srcCpu        = phase_q[1] ^ phase_q[2];
  assign srcMaster     = phase_q[0] ^ phase_q[1];
  assign fastRcReady   = 1'b1;
  assign slowRcReady   = 1'b1;
  assign xtalReady     = xtalOn;
  assign xtalFailAsync = failCmd;
endmodule : clock_source_model

`default_nettype wire

// File: sim/clock_security_output_gating_test.sv
// Self-checking bench for the clock security and output gating block.
// Assumes the source model on the far side and a 100 MHz clock.
`default_nettype none

module clock_security_output_gating_test
  import clk_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, arst_n, read, write, waitrequest, trimThreeBit, failCmd, xtalOn;
  logic [6:0]  address;
  logic [31:0] writedata, readdata;
  logic        xtalFailAsync, fastRcReady, slowRcReady, xtalReady;
  logic        srcHsiDiv, srcSlow, srcXtal, srcFast, srcCpu, srcMaster;
  logic        canClkEn, adcClkEn, awuClkEn, fastRcEnable, auxActive, debugClkEn;
  logic        clockOutputPin, failureIrq, irq;
  logic [7:0]  masterSelect, rdVal;
  logic [3:0]  rcTrimValue;
  int          failCount, nChecks;

  clock_security_output_gating DUT (.clk, .arst_n, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .xtalFailAsync, .fastRcReady, .slowRcReady, .xtalReady,
    .srcHsiDiv, .srcSlow, .srcXtal, .srcFast, .srcCpu, .srcMaster, .trimThreeBit,
    .canClkEn, .adcClkEn, .awuClkEn, .masterSelect, .fastRcEnable, .auxActive,
    .rcTrimValue, .debugClkEn, .clockOutputPin, .failureIrq, .irq);
  clock_source_model src (.clk, .arst_n, .failCmd, .xtalOn, .xtalFailAsync, .fastRcReady,
    .slowRcReady, .xtalReady, .srcHsiDiv, .srcSlow, .srcXtal, .srcFast, .srcCpu, .srcMaster);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] wd);
    @(posedge clk);
    address   <= {idx, 2'b00};
    write     <= wr;
    read      <= !wr;
    writedata <= {24'h0, wd};
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rdVal = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr

  task automatic rdChk(input logic [4:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rdVal, exp);
  endtask : rdChk

  // Outputs are registered copies, so let their updates land
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask : settle

  function automatic logic srcOf(input logic [3:0] c);
    case (c)
      SRC_HSIDIV: srcOf = srcHsiDiv;
      SRC_SLOW:   srcOf = srcSlow;
      SRC_XTAL:   srcOf = srcXtal;
      SRC_FAST:   srcOf = srcFast;
      SRC_MASTER: srcOf = srcMaster;
      4'h3:       srcOf = 1'b0;
      default:    srcOf = srcCpu;
    endcase
  endfunction : srcOf

  // Pin must follow the chosen source one cycle late
  task automatic pinCmp(input logic [3:0] code, input logic en);
    logic prev, bad;
    bad = 1'b0;
    @(negedge clk);
    prev = srcOf(code) & en;
    repeat (16) begin
      @(negedge clk);
      if (clockOutputPin !== prev) bad = 1'b1;
      prev = srcOf(code) & en;
    end
    check({7'h0, bad}, 8'h00);
  endtask : pinCmp

  task automatic waitReady;
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_CLKOUT, 8'h00);
      n++;
    end while (rdVal[CO_READY] !== 1'b1 && n < 10);
  endtask : waitReady

  task automatic countDebug(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (8) begin
      @(negedge clk);
      n += {7'h0, debugClkEn};
    end
    check(n, exp);
  endtask : countDebug

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic testReset;
    rdChk(IDX_GATE2, RST_GATE);
    check({5'h0, canClkEn, adcClkEn, awuClkEn}, 8'h07);
    rdChk(IDX_SECURITY, 8'h00);
    rdChk(IDX_CLKOUT, 8'h00);
    rdChk(IDX_TRIM, 8'h00);
    rdChk(IDX_DEBUG, 8'h00);
    rdChk(5'h02, 8'h00);
    check(masterSelect, RST_MSEL);
  endtask : testReset

  task automatic testGateTrimDebug;
    wr(IDX_GATE2, 8'h00);
    settle;
    check({5'h0, canClkEn, adcClkEn, awuClkEn}, 8'h00);
    wr(IDX_GATE2, 8'h84);
    settle;
    check({5'h0, canClkEn, adcClkEn, awuClkEn}, 8'h05);
    rdChk(IDX_GATE2, 8'h84);
    wr(IDX_TRIM, 8'h0F);
    settle;
    check({4'h0, rcTrimValue}, 8'h0F);
    trimThreeBit <= 1'b1;
    wr(IDX_TRIM, 8'h0F);
    rdChk(IDX_TRIM, 8'h07);
    trimThreeBit <= 1'b0;
    countDebug(8'h04);
    wr(IDX_DEBUG, 8'h01);
    settle;
    countDebug(8'h08);
  endtask : testGateTrimDebug

  task automatic testSecurity;
    int n;
    @(posedge clk);
    failCmd <= 1'b1;
    repeat (10) @(posedge clk);
    failCmd <= 1'b0;
    check({7'h0, auxActive}, 8'h00);
    rdChk(IDX_SECURITY, 8'h00);
    // Reserved upper bits always written as zero
    wr(IDX_SECURITY, 8'h05);
    wr(IDX_SECURITY, 8'h00);
    rdChk(IDX_SECURITY, 8'h01);
    wr(IDX_SECURITY, 8'h04);
    wr(IDX_MSEL, 8'hB4);
    rdChk(IDX_MSEL, 8'hB4);
    failCmd <= 1'b1;
    n = 0;
    while (auxActive !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    failCmd <= 1'b0;
    settle;
    check({6'h0, auxActive, failureIrq}, 8'h03);
    check(masterSelect, RST_MSEL);
    rdChk(IDX_SECURITY, 8'h0F);
    wr(IDX_INT_CTRL, 8'h00);
    settle;
    check({7'h0, fastRcEnable}, 8'h01);
    wr(IDX_SECURITY, 8'h0C);
    rdChk(IDX_SECURITY, 8'h0F);
    wr(IDX_SECURITY, 8'h08);
    rdChk(IDX_SECURITY, 8'h0B);
    check({7'h0, failureIrq}, 8'h00);
    wr(IDX_SECURITY, 8'h04);
    rdChk(IDX_SECURITY, 8'h07);
    settle;
    check({7'h0, failureIrq}, 8'h00);
  endtask : testSecurity

  task automatic testIrq;
    rdChk(IDX_IRQ_STAT, 8'h01);
    check({7'h0, irq}, 8'h00);
    wr(IDX_IRQ_EN, 8'h01);
    settle;
    check({7'h0, irq}, 8'h01);
    wr(IDX_IRQ_EN, 8'h00);
    settle;
    check({7'h0, irq}, 8'h00);
    wr(IDX_IRQ_EN, 8'h01);
    wr(IDX_IRQ_CLR, 8'h01);
    settle;
    check({7'h0, irq}, 8'h00);
    rdChk(IDX_IRQ_STAT, 8'h00);
    rdChk(IDX_IRQ_CLR, 8'h00);
  endtask : testIrq

  task automatic testClockOut;
    wr(IDX_CLKOUT, {3'b000, SRC_XTAL, 1'b1});
    rdChk(IDX_CLKOUT, {3'b010, SRC_XTAL, 1'b1});
    wr(IDX_CLKOUT, {3'b000, SRC_FAST, 1'b1});
    rdChk(IDX_CLKOUT, {3'b010, SRC_XTAL, 1'b1});
    xtalOn <= 1'b1;
    waitReady;
    check(rdVal, {3'b001, SRC_XTAL, 1'b1});
    pinCmp(SRC_XTAL, 1'b1);
    wr(IDX_CLKOUT, {3'b000, SRC_XTAL, 1'b0});
    rdChk(IDX_CLKOUT, {3'b000, SRC_XTAL, 1'b0});
    pinCmp(SRC_XTAL, 1'b0);
    // Every select code, direct sources compared cycle by cycle
    for (int c = 0; c < 16; c++) begin
      wr(IDX_CLKOUT, {3'b000, 4'(c), 1'b1});
      waitReady;
      if (c != 3) check({7'h0, rdVal[CO_READY]}, 8'h01);
      if (c < 5 || c > 10) pinCmp(4'(c), 1'b1);
    end
  endtask : testClockOut

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d, mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is a few hundred cycles; the 6000-cycle limit is ample margin
  initial begin
    #60000;
    failCount++;
    $display("wrong value at %0t: watchdog expired", $time);
    summarize;
  end

  initial begin
    failCount = 0;
    nChecks = 0;
    arst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 7'h00;
    writedata = 32'h0000_0000;
    trimThreeBit = 1'b0;
    failCmd = 1'b0;
    xtalOn = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    testReset;
    testGateTrimDebug;
    testSecurity;
    testIrq;
    testClockOut;
    summarize;
  end
endmodule : clock_security_output_gating_test

`default_nettype wire
